// [pkg/mmlc_pkg.sv]
/*
  Constants and types shared by the monitor-multiplexer and regulator
  configuration registers. Assumes a single 100 MHz system clock domain.
*/
`default_nettype none

package mmlc_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_CHG_MON    = 8'h20;
  localparam logic [7:0] ADDR_REG_VOLT   = 8'h38;
  localparam logic [7:0] CHG_MON_RESET   = 8'hF0;
  localparam logic [7:0] RDATA_UNMAPPED  = 8'h00;

  // ==========================================================================
  // Field layout
  localparam int         FS_LSB          = 4;
  localparam int         SEL_LSB         = 0;
  localparam int         FIELD_W         = 4;
  localparam int         TGT_W           = 7;

  // ==========================================================================
  // Full-scale discharge range, in units of 0.1 mA
  localparam logic [3:0]  FS_SAT_CODE    = 4'hA;
  localparam logic [11:0] FS_TABLE [0:10] = '{
    12'h052, 12'h195, 12'h2D3, 12'h40A, 12'h53D, 12'h669,
    12'h791, 12'h8B3, 12'h9D0, 12'hAE9, 12'hBB8
  };

  // ==========================================================================
  // Regulator transfer function, in units of 0.1 mV
  localparam logic [14:0] TGT_BASE       = 15'h34BC;
  localparam logic [14:0] TGT_STEP       = 15'h007D;

  // ==========================================================================
  // Measurement channels
  localparam int          NUM_ROUTES     = 10;
  localparam logic [3:0]  SEL_OFF        = 4'h0;
  localparam logic [3:0]  SEL_SYS_FIRST  = 4'hA;
  localparam int          RT_CHARGER_INPUT_V     = 0;
  localparam int          RT_CHARGER_INPUT_I     = 1;
  localparam int          RT_BATTERY_NODE_V      = 2;
  localparam int          RT_BATTERY_NODE_CHG_I  = 3;
  localparam int          RT_DSCHG_NORM  = 4;
  localparam int          RT_DSCHG_NULL  = 5;
  localparam int          RT_THERM_V     = 6;
  localparam int          RT_THERM_BIAS  = 7;
  localparam int          RT_ANALOG_GROUND        = 8;
  localparam int          RT_SYS         = 9;

  // ==========================================================================
  // On/off controller states
  typedef enum logic [1:0] {
    MMLC_OFF,
    MMLC_SW_ON,
    MMLC_CTRL_ON,
    MMLC_OTHER
  } mmlc_onoff_t;

endpackage : mmlc_pkg

`default_nettype wire

// [pkg/mmlc_sel_if.sv]
/*
  Carries the channel selection from the register logic to the channel
  decoder and the decoded route back. Assumes both ends share clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

interface mmlc_sel_if;
  logic [3:0]                       channel_code;
  logic                             mux_run;
  logic [mmlc_pkg::NUM_ROUTES-1:0]  route;
  logic                             mux_on;

  modport regs (output channel_code, output mux_run, input route, input mux_on);
  modport decode (input channel_code, input mux_run, output route, output mux_on);
endinterface : mmlc_sel_if

`default_nettype wire

// [rtl/mmlc_channel_decode.sv]
/*
  Combinational decoder from the measurement selector to one-hot switch
  enables. Assumes the caller registers the result before it leaves the block.
*/
`timescale 1ns/1ns
`default_nettype none

module mmlc_channel_decode
(
  mmlc_sel_if.decode sel
);

  // ==========================================================================
  // Decode
  always_comb
  begin
    sel.route  = '0;
    sel.mux_on = 1'b0;
    if (sel.mux_run && (sel.channel_code != mmlc_pkg::SEL_OFF))
    begin
      sel.mux_on = 1'b1;
      case (sel.channel_code)
        4'h1: sel.route[mmlc_pkg::RT_CHARGER_INPUT_V]    = 1'b1;
        4'h2: sel.route[mmlc_pkg::RT_CHARGER_INPUT_I]    = 1'b1;
        4'h3: sel.route[mmlc_pkg::RT_BATTERY_NODE_V]     = 1'b1;
        4'h4: sel.route[mmlc_pkg::RT_BATTERY_NODE_CHG_I] = 1'b1;
        4'h5: sel.route[mmlc_pkg::RT_DSCHG_NORM] = 1'b1;
        4'h6: sel.route[mmlc_pkg::RT_DSCHG_NULL] = 1'b1;
        4'h7: sel.route[mmlc_pkg::RT_THERM_V]    = 1'b1;
        4'h8: sel.route[mmlc_pkg::RT_THERM_BIAS] = 1'b1;
        4'h9: sel.route[mmlc_pkg::RT_ANALOG_GROUND]       = 1'b1;
        default: sel.route[mmlc_pkg::RT_SYS]     = 1'b1;
      endcase
    end
  end

endmodule : mmlc_channel_decode

`default_nettype wire

// [rtl/mmlc_top.sv]
/*
  Charger monitor/multiplexer configuration register and regulator voltage
  configuration register, with decoded controls for the analog circuits.
  Assumes the serial port engine presents one-cycle register read and write
  strobes synchronous to clk_sys, and that the one-time-programmable default
  bits are stable whenever a system reset is in progress.
*/
// Operation
// - Upper nibble full-scale select, defaults ones.
// - Full-scale code saturates at 300mA.
// - Selector zero: multiplexer off, output floats.
// - Codes one-three: input voltage, current, battery.
// - Codes five-nine: discharge, thermistor, bias, ground.
// - Codes ten-fifteen route system supply.
// - Multiplexer works only in on states.
// - Seven-bit regulator code, 12.5mV steps.
`timescale 1ns/1ns
`default_nettype none

module mmlc_top
(
  input  wire  logic                             clk_sys,
  input  wire  logic                             rst,
  input  wire  logic                             system_reset_event,
  input  wire  logic [7:0]                       otp_regulator_default,
  input  wire  logic [7:0]                       reg_addr,
  input  wire  logic [7:0]                       reg_wdata,
  input  wire  logic                             reg_wr,
  input  wire  logic                             reg_rd,
  input  wire  mmlc_pkg::mmlc_onoff_t            onoff_state,
  input  wire  logic                             charging_active,
  output logic [7:0]                             reg_rdata,
  output logic                                   reg_rvalid,
  output logic [3:0]                             discharge_fullscale_sel,
  output logic [11:0]                            discharge_fullscale_dma,
  output logic [3:0]                             measure_channel_sel,
  output logic [mmlc_pkg::NUM_ROUTES-1:0]        measure_route,
  output logic                                   measure_mux_on,
  output logic                                   analog_measure_out_oe_n,
  output logic                                   charge_monitor_valid,
  output logic [6:0]                             regulator_target_code,
  output logic [14:0]                            regulator_target_dmv
);

  // All assertions in this module share one clock and one reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Register state
  logic [7:0]  chg_mon_r;
  logic [7:0]  chg_mon_nxt;
  logic [7:0]  reg_volt_r;
  logic [7:0]  reg_volt_nxt;
  logic        otp_load_r;
  logic        otp_load_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;

  always_comb
  begin
    chg_mon_nxt  = chg_mon_r;
    reg_volt_nxt = reg_volt_r;
    otp_load_nxt = 1'b0;
    rdata_nxt    = rdata_r;
    rvalid_nxt   = reg_rd;
    if (system_reset_event || otp_load_r)
    begin
      chg_mon_nxt  = mmlc_pkg::CHG_MON_RESET;
      reg_volt_nxt = otp_regulator_default;
    end
    else if (reg_wr)
    begin
      if (reg_addr == mmlc_pkg::ADDR_CHG_MON)
        chg_mon_nxt = reg_wdata;
      if (reg_addr == mmlc_pkg::ADDR_REG_VOLT)
        reg_volt_nxt = reg_wdata;
    end
    if (reg_rd)
    begin
      case (reg_addr)
        mmlc_pkg::ADDR_CHG_MON:  rdata_nxt = chg_mon_r;
        mmlc_pkg::ADDR_REG_VOLT: rdata_nxt = reg_volt_r;
        default:                 rdata_nxt = mmlc_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  // An asynchronous reset may only load constants, so the programmed
  // regulator default is fetched on the first edge after release.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      chg_mon_r  <= mmlc_pkg::CHG_MON_RESET;
      reg_volt_r <= 8'h00;
      otp_load_r <= 1'b1;
      rdata_r    <= 8'h00;
      rvalid_r   <= 1'b0;
    end
    else
    begin
      chg_mon_r  <= chg_mon_nxt;
      reg_volt_r <= reg_volt_nxt;
      otp_load_r <= otp_load_nxt;
      rdata_r    <= rdata_nxt;
      rvalid_r   <= rvalid_nxt;
    end
  end

  // ==========================================================================
  // Channel decode
  mmlc_sel_if sel ();

  logic [3:0] fs_code;
  logic [3:0] fs_index;

  assign fs_code          = chg_mon_r[mmlc_pkg::FS_LSB +: mmlc_pkg::FIELD_W];
  assign sel.channel_code = chg_mon_r[mmlc_pkg::SEL_LSB +: mmlc_pkg::FIELD_W];
  assign sel.mux_run      = (onoff_state == mmlc_pkg::MMLC_SW_ON) ||
                            (onoff_state == mmlc_pkg::MMLC_CTRL_ON);
  assign fs_index         = (fs_code >= mmlc_pkg::FS_SAT_CODE) ? mmlc_pkg::FS_SAT_CODE : fs_code;

  mmlc_channel_decode mmlc_channel_decode_inst
  (
    .sel (sel.decode)
  );

  // ==========================================================================
  // Output registers
  logic [mmlc_pkg::NUM_ROUTES-1:0] route_r;
  logic [mmlc_pkg::NUM_ROUTES-1:0] route_nxt;
  logic                            mux_on_r;
  logic                            mux_on_nxt;
  logic                            oe_n_r;
  logic                            oe_n_nxt;
  logic                            chg_valid_r;
  logic                            chg_valid_nxt;
  logic [11:0]                     fs_dma_r;
  logic [11:0]                     fs_dma_nxt;
  logic [14:0]                     tgt_dmv_r;
  logic [14:0]                     tgt_dmv_nxt;
  logic [14:0]                     tgt_prod;

  assign tgt_prod = 15'(reg_volt_r[mmlc_pkg::TGT_W-1:0]) * mmlc_pkg::TGT_STEP;

  always_comb
  begin
    route_nxt     = sel.route;
    mux_on_nxt    = sel.mux_on;
    oe_n_nxt      = ~sel.mux_on;
    chg_valid_nxt = sel.route[mmlc_pkg::RT_BATTERY_NODE_CHG_I] & charging_active;
    fs_dma_nxt    = mmlc_pkg::FS_TABLE[fs_index];
    tgt_dmv_nxt   = mmlc_pkg::TGT_BASE + tgt_prod;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      route_r     <= '0;
      mux_on_r    <= 1'b0;
      oe_n_r      <= 1'b1;
      chg_valid_r <= 1'b0;
      fs_dma_r    <= 12'h000;
      tgt_dmv_r   <= 15'h0000;
    end
    else
    begin
      route_r     <= route_nxt;
      mux_on_r    <= mux_on_nxt;
      oe_n_r      <= oe_n_nxt;
      chg_valid_r <= chg_valid_nxt;
      fs_dma_r    <= fs_dma_nxt;
      tgt_dmv_r   <= tgt_dmv_nxt;
    end
  end

  // The top bit of the regulator byte is kept for read-back only; it
  // drives nothing, so a careless write cannot disturb the regulator.
  assign reg_rdata               = rdata_r;
  assign reg_rvalid              = rvalid_r;
  assign discharge_fullscale_sel = chg_mon_r[mmlc_pkg::FS_LSB +: mmlc_pkg::FIELD_W];
  assign discharge_fullscale_dma = fs_dma_r;
  assign measure_channel_sel     = chg_mon_r[mmlc_pkg::SEL_LSB +: mmlc_pkg::FIELD_W];
  assign measure_route           = route_r;
  assign measure_mux_on          = mux_on_r;
  assign analog_measure_out_oe_n = oe_n_r;
  assign charge_monitor_valid    = chg_valid_r;
  assign regulator_target_code   = reg_volt_r[mmlc_pkg::TGT_W-1:0];
  assign regulator_target_dmv    = tgt_dmv_r;

  // ==========================================================================
  // Assertions

  logic run_now;
  assign run_now = sel.mux_run;

  sequence s_chg_write;
    reg_wr && !system_reset_event && !otp_load_r && (reg_addr == 8'h20);
  endsequence

  sequence s_volt_write;
    reg_wr && !system_reset_event && !otp_load_r && (reg_addr == 8'h38);
  endsequence

  property p_fs_default;
    system_reset_event |=> (discharge_fullscale_sel == 4'hF) && (measure_channel_sel == 4'h0);
  endproperty
  a_fs_default: assert property (p_fs_default) else $error("charger byte not reset");

  property p_fs_saturate;
    (fs_code >= 4'hA) [*2] |=> (discharge_fullscale_dma == 12'hBB8);
  endproperty
  a_fs_saturate: assert property (p_fs_saturate) else $error("full-scale not clamped");

  property p_off_float;
    (s_chg_write ##0 (reg_wdata[3:0] == 4'h0)) |=> ##1 (analog_measure_out_oe_n && (measure_route == '0));
  endproperty
  a_off_float: assert property (p_off_float) else $error("output driven while off");

  property p_battery_node_volt;
    (run_now && (measure_channel_sel == 4'h3)) |=> (measure_route == 10'h004) && !analog_measure_out_oe_n;
  endproperty
  a_battery_node_volt: assert property (p_battery_node_volt) else $error("battery channel wrong");

  property p_chg_valid;
    charge_monitor_valid |-> $past(charging_active) && (measure_route == 10'h008);
  endproperty
  a_chg_valid: assert property (p_chg_valid) else $error("charge current valid wrongly");

  property p_analog_ground;
    (run_now && (measure_channel_sel == 4'h9)) |=> (measure_route == 10'h100);
  endproperty
  a_analog_ground: assert property (p_analog_ground) else $error("ground channel wrong");

  property p_sys_codes;
    (run_now && (measure_channel_sel >= 4'hA)) |=> (measure_route == 10'h200) && measure_mux_on;
  endproperty
  a_sys_codes: assert property (p_sys_codes) else $error("supply channel wrong");

  property p_not_on;
    !run_now |=> !measure_mux_on && (measure_route == '0) && analog_measure_out_oe_n;
  endproperty
  a_not_on: assert property (p_not_on) else $error("mux active outside on states");

  property p_volt_map;
    s_volt_write |=> (regulator_target_code == $past(reg_wdata[6:0]))
                     ##1 (regulator_target_dmv == 15'h34BC + 15'($past(reg_wdata[6:0], 2)) * 15'h7D);
  endproperty
  a_volt_map: assert property (p_volt_map) else $error("regulator code or voltage wrong");

  property p_otp_load;
    system_reset_event |=> (reg_volt_r == $past(otp_regulator_default)) && (chg_mon_r == 8'hF0);
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("defaults not restored");

endmodule : mmlc_top

`default_nettype wire

// [testbench/mmlc_host_model.sv]
/*
  Host processor model that reaches the configuration registers through
  the byte register port. Assumes one-cycle strobes sampled on clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none

module mmlc_host_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // ==========================================================================
  // Register access
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == mmlc_pkg::ADDR_REG_VOLT)
      v[7] = 1'b0;
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // Released lines toggle so that a stale value is never mistaken for data.
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    ok = 1'b0;
    d  = 8'h00;
    for (n = 0; n < 4 && !ok; n++)
    begin
      #1;
      if (reg_rvalid === 1'b1)
      begin
        ok = 1'b1;
        d  = reg_rdata;
      end
      else
        @(posedge clk_sys);
    end
  endtask : read_reg

  task automatic park_mux;
    write_reg(mmlc_pkg::ADDR_CHG_MON, 8'hF0);
  endtask : park_mux
endmodule : mmlc_host_model

`default_nettype wire

// [testbench/mmlc_top_tb.sv]
/*
  Self-checking bench for the monitor and regulator configuration registers.
  Assumes the host model drives the register port and this module the rest.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
    end \
  end

module mmlc_top_tb;
  logic                         clk_sys;
  logic                         rst;
  logic                         system_reset_event;
  logic [7:0]                   otp_regulator_default;
  logic [7:0]                   reg_addr;
  logic [7:0]                   reg_wdata;
  logic                         reg_wr;
  logic                         reg_rd;
  mmlc_pkg::mmlc_onoff_t        onoff_state;
  logic                         charging_active;
  logic [7:0]                   reg_rdata;
  logic                         reg_rvalid;
  logic [3:0]                   fs_sel;
  logic [11:0]                  fs_dma;
  logic [3:0]                   ch_sel;
  logic [9:0]                   route;
  logic                         mux_on;
  logic                         out_oe_n;
  logic                         chg_valid;
  logic [6:0]                   tgt_code;
  logic [14:0]                  tgt_dmv;
  int                           fails;
  int                           total_checks;
  logic                         on;
  logic [6:0]                   volt_codes [0:2] = '{7'h00, 7'h7F, 7'h40};

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  mmlc_top mmlc_top_inst (.clk_sys(clk_sys), .rst(rst), .system_reset_event(system_reset_event),
    .otp_regulator_default(otp_regulator_default), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .onoff_state(onoff_state),
    .charging_active(charging_active), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .discharge_fullscale_sel(fs_sel), .discharge_fullscale_dma(fs_dma),
    .measure_channel_sel(ch_sel), .measure_route(route), .measure_mux_on(mux_on),
    .analog_measure_out_oe_n(out_oe_n), .charge_monitor_valid(chg_valid),
    .regulator_target_code(tgt_code), .regulator_target_dmv(tgt_dmv));

  mmlc_host_model mmlc_host_model_inst (.clk_sys(clk_sys), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));

  // ==========================================================================
  // Helpers
  task automatic final_report;
    if (fails == 0 && total_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    mmlc_host_model_inst.read_reg(a, d, ok);
    if (!ok)
    begin
      fails++;
      final_report();
    end
    `CHK(d & mask, exp & mask)
  endtask : rd_chk

  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  function automatic logic [9:0] exp_route(input logic [3:0] s);
    if (s == 4'h0)
      return 10'h000;
    if (s >= 4'hA)
      return 10'h200;
    return 10'h001 << (s - 4'h1);
  endfunction : exp_route

  // ==========================================================================
  // Sequence
  initial
  begin
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    system_reset_event = 1'b0;
    otp_regulator_default = 8'hC5;
    onoff_state = mmlc_pkg::MMLC_SW_ON;
    charging_active = 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    rd_chk(8'h20, 8'hFF, 8'hF0);
    rd_chk(8'h38, 8'h7F, 8'hC5);
    `CHK(fs_dma, 12'hBB8)
    for (int c = 0; c < 16; c++)
    begin
      mmlc_host_model_inst.write_reg(8'h20, {c[3:0], 4'h0});
      settle();
      `CHK(fs_dma, mmlc_pkg::FS_TABLE[(c > 10) ? 10 : c])
      `CHK(fs_sel, c[3:0])
    end
    for (int s = 0; s < 16; s++)
    begin
      mmlc_host_model_inst.write_reg(8'h20, {4'h5, s[3:0]});
      settle();
      `CHK(route, exp_route(s[3:0]))
      `CHK(ch_sel, s[3:0])
      `CHK(out_oe_n, (s == 0))
      `CHK(chg_valid, (s == 4))
      rd_chk(8'h20, 8'hFF, {4'h5, s[3:0]});
    end
    `CHK(route, 10'h200)
    mmlc_host_model_inst.write_reg(8'h20, 8'h54);
    charging_active <= 1'b0;
    settle();
    `CHK(chg_valid, 1'b0)
    mmlc_host_model_inst.write_reg(8'h20, 8'h53);
    for (int st = 0; st < 4; st++)
    begin
      @(posedge clk_sys);
      onoff_state <= mmlc_pkg::mmlc_onoff_t'(st[1:0]);
      settle();
      on = (st == 1) || (st == 2);
      `CHK(route, on ? 10'h004 : 10'h000)
      `CHK(mux_on, on)
    end
    @(posedge clk_sys);
    onoff_state <= mmlc_pkg::MMLC_CTRL_ON;
    mmlc_host_model_inst.park_mux();
    settle();
    `CHK(out_oe_n, 1'b1)
    foreach (volt_codes[i])
    begin
      mmlc_host_model_inst.write_reg(8'h38, {1'b1, volt_codes[i]});
      settle();
      `CHK(tgt_code, volt_codes[i])
      `CHK(tgt_dmv, 15'h34BC + 15'(volt_codes[i]) * 15'h007D)
    end
    mmlc_host_model_inst.write_reg(8'h21, 8'h77);
    rd_chk(8'h21, 8'hFF, 8'h00);
    rd_chk(8'h20, 8'hFF, 8'hF0);
    @(posedge clk_sys);
    otp_regulator_default <= 8'h2A;
    fork
      mmlc_host_model_inst.write_reg(8'h20, 8'h3C);
      begin
        @(posedge clk_sys);
        system_reset_event <= 1'b1;
        @(posedge clk_sys);
        system_reset_event <= 1'b0;
      end
    join
    settle();
    rd_chk(8'h20, 8'hFF, 8'hF0);
    rd_chk(8'h38, 8'h7F, 8'h2A);
    `CHK(tgt_dmv, 15'h34BC + 15'h002A * 15'h007D)
    final_report();
  end
endmodule : mmlc_top_tb

`undef CHK
`default_nettype wire
